// *** logic/ddif_pkg.sv ***
// ddif_pkg: function codes, timing constants and command carrier for the
// digital input decoder. assumes one 25 MHz core clock.
`default_nettype none
package ddif_pkg;
	localparam int N_TERM = 5;
	localparam logic [5:0] FN_NONE = 6'h00;
	localparam logic [5:0] FN_RESET = 6'h01;
	localparam logic [5:0] FN_COAST_N = 6'h02;
	localparam logic [5:0] FN_CLR_FREEWHEEL_N = 6'h03;
	localparam logic [5:0] FN_QSTOP_N = 6'h04;
	localparam logic [5:0] FN_DCBRAKE_N = 6'h05;
	localparam logic [5:0] FN_STOP_N = 6'h06;
	localparam logic [5:0] FN_START = 6'h07;
	localparam logic [5:0] FN_LATCH_START = 6'h08;
	localparam logic [5:0] FN_REVERSE = 6'h09;
	localparam logic [5:0] FN_REV_START = 6'h0a;
	localparam logic [5:0] FN_START_CW = 6'h0b;
	localparam logic [5:0] FN_START_CCW = 6'h0c;
	localparam logic [5:0] FN_INCH = 6'h0d;
	localparam logic [5:0] FN_FREEZE_REF = 6'h0e;
	localparam logic [5:0] FN_FREEZE_OUT = 6'h0f;
	localparam logic [5:0] FN_SPEED_UP = 6'h10;
	localparam logic [5:0] FN_SPEED_DN = 6'h11;
	localparam logic [5:0] FN_CATCH_UP = 6'h13;
	localparam logic [5:0] FN_SLOW_DN = 6'h14;
	localparam logic [5:0] FN_RAMP2 = 6'h15;
	localparam logic [5:0] FN_PRESET_LSB = 6'h16;
	localparam logic [5:0] FN_PRESET_MSB = 6'h17;
	localparam logic [5:0] FN_PRESET_ON = 6'h18;
	localparam logic [5:0] FN_PRECISE_STOP_N = 6'h1a;
	localparam logic [5:0] FN_PRECISE_SS = 6'h1b;
	localparam logic [5:0] FN_PULSE_REF = 6'h1c;
	localparam logic [5:0] FN_PULSE_FB = 6'h1d;
	localparam logic [5:0] FN_PULSE_IN = 6'h1e;
	localparam logic [5:0] FN_SETUP_LSB = 6'h1f;
	localparam logic [5:0] FN_SETUP_MSB = 6'h20;
	localparam logic [5:0] FN_RESET_START = 6'h21;
	localparam logic [5:0] FN_ENC_REF = 6'h22;
	localparam logic [5:0] FN_ENC_FB = 6'h23;
	localparam logic [5:0] FN_ENC_IN = 6'h24;
	// reset values of the five function selects
	localparam logic [29:0] SEL_RESET = {6'h00, 6'h0d, 6'h03, 6'h09, 6'h07};
	localparam int CLK_HZ = 25_000_000;
	localparam int PULSE_MIN_MS = 14;
	localparam int PULSE_MIN_CYC = (CLK_HZ / 1000) * PULSE_MIN_MS;
	localparam int GLITCH_CYC = 4;
	localparam logic [2:0] GLITCH_MAX = 3'h3;

	typedef struct packed {
		logic coast;
		logic quick_stop;
		logic dc_brake;
		logic ramp_stop;
		logic run;
		logic reverse;
		logic dir_lock_cw;
		logic dir_lock_ccw;
		logic inch;
		logic alarm_clear;
		logic ramp2;
		logic [1:0] preset_sel;
		logic preset_on;
		logic [1:0] setup_sel;
		logic catch_up;
		logic slow_down;
		logic freeze_ref;
		logic freeze_out;
		logic step_up;
		logic step_dn;
		logic precise_stop;
	} ddif_cmd_s;
endpackage : ddif_pkg
`default_nettype wire

// *** logic/ddif_top.sv ***
// ddif_top: conditions the five input terminals and turns their selected
// functions into drive commands. assumes pins asynchronous, selects static.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - each of five terminals has its own function select
// - codes 0..13: none, reset, inverse stops, start variants, inch
// - codes 14..17, 19..24, 31..33 valid on every terminal
// - encoder codes 34..36 on last two terminals only, identical settings
// - terminal four refuses pulse ref/feedback when output is pulse output
// - a terminal with no function is ignored
// - reset clears alarm on rising edge; trip-locked alarms stay
// - coast inverse low switches output stage off at once
// - clear-and-freewheel low coasts; reset on its falling edge
// - quick-stop inverse low ramps down on quick-stop ramp
// - direct_current_brake_n low brakes only if time and voltage nonzero
// - stop inverse low ramps to standstill on selected ramp
// - start high runs, low stops
// - latched start after 14 ms high; runs until stop
// - reversing inverts direction, no start; ignored in closed loop
// - reverse-and-start starts and reverses; ignored in closed loop
// - cw-only and ccw-only starts lock rotation direction
// - inch forces jog frequency; suppressed by coast, quick stop, dc brake
// - freeze holds reference, kept over stop and mains loss
// - speed up/down step once per 14 ms high then 14 ms low, only while freeze ref or freeze out is active
// - preset selects form a two-bit binary code
module ddif_top (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [4:0] term_i,
	input wire logic [29:0] func_sel_i,
	input wire logic pulse_out_mode_i,
	input wire logic closed_loop_i,
	input wire logic dc_time_nonzero_i,
	input wire logic dc_volt_nonzero_i,
	input wire logic alarm_trip_locked_i,
	output logic [29:0] func_eff_o,
	output logic [4:0] sel_refused_o,
	output ddif_pkg::ddif_cmd_s cmd_o
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic code_ok(input int t, input logic [5:0] c);
		logic ok;
		ok = 1'b0;
		if (c <= ddif_pkg::FN_SPEED_DN) begin
			ok = 1'b1;
		end else if (c >= ddif_pkg::FN_CATCH_UP && c <= ddif_pkg::FN_PRESET_ON) begin
			ok = 1'b1;
		end else if (c >= ddif_pkg::FN_SETUP_LSB && c <= ddif_pkg::FN_RESET_START) begin
			ok = 1'b1;
		end else if (c == ddif_pkg::FN_PRECISE_STOP_N || c == ddif_pkg::FN_PRECISE_SS) begin
			ok = (t < 2);
		end else if (c == ddif_pkg::FN_PULSE_REF || c == ddif_pkg::FN_PULSE_FB) begin
			ok = (t >= 3);
		end else if (c == ddif_pkg::FN_PULSE_IN) begin
			ok = (t == 4);
		end else if (c >= ddif_pkg::FN_ENC_REF && c <= ddif_pkg::FN_ENC_IN) begin
			ok = (t >= 3);
		end
		return ok;
	endfunction : code_ok

	////////////////////////////////////////////////////////////////////////
	// synchroniser and deglitch filter per terminal
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [4:0] lvl_reg;
	logic [4:0] lvl_d_reg;
	logic [2:0] flt_cnt_reg [5];
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end else begin
			sync1_reg <= term_i;
			sync2_reg <= sync1_reg;
		end
	end
	genvar g;
	// one process for all terminals keeps each filter register single-driven
	always_ff @(posedge core_clk_i) begin
		for (int t = 0; t < ddif_pkg::N_TERM; t++) begin
			if (rst_i) begin
				flt_cnt_reg[t] <= 3'h0;
				lvl_reg[t] <= 1'b0;
			end else if (sync2_reg[t] == lvl_reg[t]) begin
				flt_cnt_reg[t] <= 3'h0;
			end else if (flt_cnt_reg[t] == ddif_pkg::GLITCH_MAX) begin
				flt_cnt_reg[t] <= 3'h0;
				lvl_reg[t] <= sync2_reg[t];
			end else begin
				flt_cnt_reg[t] <= flt_cnt_reg[t] + 3'h1;
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			lvl_d_reg <= 5'h00;
		end else begin
			lvl_d_reg <= lvl_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// effective function per terminal; refused codes fall back to none
	logic [5:0] eff [5];
	logic [4:0] refused;
	for (g = 0; g < ddif_pkg::N_TERM; g++) begin : g_sel
		wire logic [5:0] req = func_sel_i[6*g +: 6];
		wire logic pulse_blk = (g == 3) && pulse_out_mode_i
			&& (req == ddif_pkg::FN_PULSE_REF || req == ddif_pkg::FN_PULSE_FB);
		wire logic enc_code = req >= ddif_pkg::FN_ENC_REF && req <= ddif_pkg::FN_ENC_IN;
		wire logic enc_mismatch = enc_code && (func_sel_i[23:18] != func_sel_i[29:24]);
		assign refused[g] = !code_ok(g, req) || pulse_blk || enc_mismatch;
		assign eff[g] = refused[g] ? ddif_pkg::FN_NONE : req;
	end

	wire logic [29:0] eff_all = {eff[4], eff[3], eff[2], eff[1], eff[0]};

	// level, rise and fall of all terminals carrying a given function;
	// a terminal set to none matches nothing, so it is ignored.
	// selects come in as an argument so continuous users follow a select change
	function automatic logic any_hi(input logic [5:0] f, input logic [4:0] l,
		input logic [29:0] e);
		logic r;
		r = 1'b0;
		for (int t = 0; t < ddif_pkg::N_TERM; t++) begin
			if (e[6*t +: 6] == f && f != ddif_pkg::FN_NONE && l[t]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction : any_hi

	// edges ignored until the sync and filter chain has refilled after reset,
	// otherwise a pin already high at release would look like a fresh edge
	logic [3:0] settle_reg;
	wire logic settled = settle_reg == 4'(ddif_pkg::GLITCH_CYC + 3);
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			settle_reg <= 4'h0;
		end else if (!settled) begin
			settle_reg <= settle_reg + 4'h1;
		end
	end
	wire logic [4:0] rise = lvl_reg & ~lvl_d_reg & {5{settled}};
	wire logic [4:0] fall = ~lvl_reg & lvl_d_reg & {5{settled}};
	// inverse functions: active when some terminal carrying them is low
	wire logic coast = any_hi(ddif_pkg::FN_COAST_N, ~lvl_reg, eff_all)
		|| any_hi(ddif_pkg::FN_CLR_FREEWHEEL_N, ~lvl_reg, eff_all);
	wire logic qstop = any_hi(ddif_pkg::FN_QSTOP_N, ~lvl_reg, eff_all);
	wire logic dcbrk = any_hi(ddif_pkg::FN_DCBRAKE_N, ~lvl_reg, eff_all)
		&& dc_time_nonzero_i && dc_volt_nonzero_i;
	wire logic rstop = any_hi(ddif_pkg::FN_STOP_N, ~lvl_reg, eff_all)
		|| any_hi(ddif_pkg::FN_PRECISE_STOP_N, ~lvl_reg, eff_all);
	wire logic any_stop = coast || qstop || dcbrk || rstop;
	wire logic clr_ev = (any_hi(ddif_pkg::FN_RESET, rise, eff_all)
		|| any_hi(ddif_pkg::FN_CLR_FREEWHEEL_N, fall, eff_all)
		|| any_hi(ddif_pkg::FN_RESET_START, rise, eff_all))
		&& !alarm_trip_locked_i;
	wire logic open_loop = !closed_loop_i;
	wire logic rev_start = any_hi(ddif_pkg::FN_REV_START, lvl_reg, eff_all)
		&& open_loop;
	wire logic cw = any_hi(ddif_pkg::FN_START_CW, lvl_reg, eff_all);
	wire logic ccw = any_hi(ddif_pkg::FN_START_CCW, lvl_reg, eff_all);
	wire logic lvl_start = any_hi(ddif_pkg::FN_START, lvl_reg, eff_all)
		|| any_hi(ddif_pkg::FN_RESET_START, lvl_reg, eff_all)
		|| any_hi(ddif_pkg::FN_PRECISE_SS, lvl_reg, eff_all);
	wire logic latch_in = any_hi(ddif_pkg::FN_LATCH_START, lvl_reg, eff_all);
	wire logic up_in = any_hi(ddif_pkg::FN_SPEED_UP, lvl_reg, eff_all);
	wire logic dn_in = any_hi(ddif_pkg::FN_SPEED_DN, lvl_reg, eff_all);
	wire logic frz_ref = any_hi(ddif_pkg::FN_FREEZE_REF, lvl_reg, eff_all);
	wire logic frz_out = any_hi(ddif_pkg::FN_FREEZE_OUT, lvl_reg, eff_all);

	////////////////////////////////////////////////////////////////////////
	// latched start: 14 ms high arms a run that only a stop ends
	logic [18:0] latch_cnt_reg;
	logic latched_run_reg;
	wire logic latch_done = latch_cnt_reg == 19'(ddif_pkg::PULSE_MIN_CYC - 1);
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			latch_cnt_reg <= 19'h0;
			latched_run_reg <= 1'b0;
		end else begin
			latch_cnt_reg <= (latch_in && !latch_done) ? latch_cnt_reg + 19'h1
				: (latch_in ? latch_cnt_reg : 19'h0);
			if (any_stop) begin
				latched_run_reg <= 1'b0;
			end else if (latch_in && latch_done) begin
				latched_run_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// speed step qualifier: 14 ms high then 14 ms low per step; a step fires only while frozen
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HIGH = 3'b010,
		ST_LOW = 3'b100
	} ddif_step_e;
	ddif_step_e step_st_reg;
	logic [18:0] step_cnt_reg;
	logic step_dn_reg;
	logic step_fire;
	wire logic step_in = up_in || dn_in;
	wire logic step_full = step_cnt_reg == 19'(ddif_pkg::PULSE_MIN_CYC - 1);
	wire logic frozen = frz_ref || frz_out;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			step_st_reg <= ST_IDLE;
			step_cnt_reg <= 19'h0;
			step_dn_reg <= 1'b0;
		end else begin
			unique case (step_st_reg)
				ST_IDLE: begin
					step_cnt_reg <= 19'h0;
					if (step_in) begin
						step_st_reg <= ST_HIGH;
						step_dn_reg <= dn_in;
					end
				end
				ST_HIGH: begin
					if (!step_in) begin
						step_st_reg <= ST_IDLE;
					end else if (step_full) begin
						step_st_reg <= ST_LOW;
						step_cnt_reg <= 19'h0;
					end else begin
						step_cnt_reg <= step_cnt_reg + 19'h1;
					end
				end
				ST_LOW: begin
					if (step_in) begin
						step_cnt_reg <= 19'h0; // low gap restarts
					end else if (step_full) begin
						step_st_reg <= ST_IDLE;
					end else begin
						step_cnt_reg <= step_cnt_reg + 19'h1;
					end
				end
			endcase
		end
	end
	assign step_fire = (step_st_reg == ST_LOW) && !step_in && step_full && frozen;

	////////////////////////////////////////////////////////////////////////
	// command outputs, all registered
	ddif_pkg::ddif_cmd_s cmd_next;
	always_comb begin
		cmd_next = '0;
		cmd_next.coast = coast;
		cmd_next.quick_stop = qstop;
		cmd_next.dc_brake = dcbrk;
		cmd_next.ramp_stop = rstop;
		cmd_next.run = !any_stop && (lvl_start || latched_run_reg || rev_start
			|| cw || ccw);
		cmd_next.reverse = rev_start
			|| (any_hi(ddif_pkg::FN_REVERSE, lvl_reg, eff_all) && open_loop);
		cmd_next.dir_lock_cw = cw;
		cmd_next.dir_lock_ccw = ccw;
		cmd_next.inch = any_hi(ddif_pkg::FN_INCH, lvl_reg, eff_all)
			&& !(coast || qstop || dcbrk);
		cmd_next.alarm_clear = clr_ev;
		cmd_next.ramp2 = any_hi(ddif_pkg::FN_RAMP2, lvl_reg, eff_all);
		cmd_next.preset_sel = {any_hi(ddif_pkg::FN_PRESET_MSB, lvl_reg, eff_all),
			any_hi(ddif_pkg::FN_PRESET_LSB, lvl_reg, eff_all)};
		cmd_next.preset_on = any_hi(ddif_pkg::FN_PRESET_ON, lvl_reg, eff_all);
		cmd_next.setup_sel = {any_hi(ddif_pkg::FN_SETUP_MSB, lvl_reg, eff_all),
			any_hi(ddif_pkg::FN_SETUP_LSB, lvl_reg, eff_all)};
		cmd_next.catch_up = any_hi(ddif_pkg::FN_CATCH_UP, lvl_reg, eff_all)
			&& !any_hi(ddif_pkg::FN_SLOW_DN, lvl_reg, eff_all);
		cmd_next.slow_down = any_hi(ddif_pkg::FN_SLOW_DN, lvl_reg, eff_all);
		cmd_next.freeze_ref = frz_ref;
		cmd_next.freeze_out = frz_out;
		cmd_next.step_up = step_fire && !step_dn_reg;
		cmd_next.step_dn = step_fire && step_dn_reg;
		cmd_next.precise_stop = any_hi(ddif_pkg::FN_PRECISE_STOP_N, ~lvl_reg, eff_all);
	end
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cmd_o <= '0;
			func_eff_o <= ddif_pkg::SEL_RESET;
			sel_refused_o <= 5'h00;
		end else begin
			cmd_o <= cmd_next;
			func_eff_o <= eff_all;
			sel_refused_o <= refused;
		end
	end

	////////////////////////////////////////////////////////////////////////
	coast_out_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		coast |=> cmd_o.coast) else $error("coast not issued");
	inch_block_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		cmd_o.inch |-> !(cmd_o.coast || cmd_o.quick_stop || cmd_o.dc_brake))
		else $error("inch during stop");
	dc_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(!dc_time_nonzero_i || !dc_volt_nonzero_i) |=> !cmd_o.dc_brake)
		else $error("dc brake without settings");
	run_stop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		any_stop |=> !cmd_o.run) else $error("run during stop");
	trip_lock_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		alarm_trip_locked_i |=> !cmd_o.alarm_clear) else $error("locked alarm cleared");
	loop_rev_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		closed_loop_i |=> !cmd_o.reverse) else $error("reverse in closed loop");
	pulse_blk_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pulse_out_mode_i |=> func_eff_o[23:18] != ddif_pkg::FN_PULSE_REF)
		else $error("pulse ref on terminal four");
	step_pair_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		cmd_o.step_up |-> !$past(cmd_o.step_up)) else $error("step repeated");
	pin_pos_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		1'b1 |=> func_eff_o[17:12] != ddif_pkg::FN_PRECISE_SS)
		else $error("precise code on terminal three");
endmodule : ddif_top
`default_nettype wire

// *** dv/ddif_contacts.sv ***
// ddif_contacts: model of the contacts or controller outputs on the five terminals.
// assumes the bench clock and a requested level per terminal, changed after an edge.
`default_nettype none
module ddif_contacts (
	input wire logic clk_i,
	input wire logic [4:0] want_i,
	input wire logic bounce_i,
	output logic [4:0] term_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] last_reg = 5'h00;
	logic [4:0] diff_reg = 5'h00;
	logic [2:0] bcnt_reg = 3'h0;
	////////////////////////////////////////////////////////////////////////////
	// contact bounce: runs of at most two cycles, so a deglitcher must hide them
	always_ff @(posedge clk_i) begin
		last_reg <= want_i;
		if (bounce_i && want_i != last_reg) begin
			bcnt_reg <= 3'h6;
			diff_reg <= want_i ^ last_reg;
		end else if (bcnt_reg != 3'h0) begin
			bcnt_reg <= bcnt_reg - 3'h1;
		end
	end
	// requested levels held until the next request
	assign term_o = want_i ^ (bcnt_reg[1] ? diff_reg : 5'h00);
endmodule : ddif_contacts
`default_nettype wire

// *** dv/test_ddif_top.sv ***
// test_ddif_top: self-checking bench for the terminal function decoder.
// assumes ddif_pkg and ddif_top compiled first; contacts model drives the pins.
`default_nettype none
module test_ddif_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [29:0] func_sel = 30'h0;
	logic pulse_mode = 1'b0;
	logic closed_loop = 1'b0;
	logic dct = 1'b0;
	logic dcv = 1'b0;
	logic trip = 1'b0;
	logic [4:0] want = 5'h00;
	logic bounce = 1'b0;
	logic [4:0] term;
	logic [29:0] func_eff;
	logic [4:0] refused;
	ddif_pkg::ddif_cmd_s cmd;
	int mismatches = 0;
	int checked = 0;
	int pulses = 0;
	int ok_codes[27] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17,
		19, 20, 21, 22, 23, 24, 31, 32, 33};
	ddif_contacts ddif_contacts_inst (.clk_i(core_clk), .want_i(want), .bounce_i(bounce),
		.term_o(term));
	ddif_top ddif_top_inst (.core_clk_i(core_clk), .rst_i(rst), .term_i(term),
		.func_sel_i(func_sel), .pulse_out_mode_i(pulse_mode), .closed_loop_i(closed_loop),
		.dc_time_nonzero_i(dct), .dc_volt_nonzero_i(dcv), .alarm_trip_locked_i(trip),
		.func_eff_o(func_eff), .sel_refused_o(refused), .cmd_o(cmd));
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (!rst && cmd.alarm_clear === 1'b1) pulses++;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	function automatic bit refd(int t, int c, bit pm, int other);
		if (c == 18 || c == 25 || c > 36) return 1'b1;
		if (c == 26 || c == 27) return t > 1;
		if (c == 28 || c == 29) return t < 3 || (t == 3 && pm);
		if (c == 30) return t != 4;
		if (c >= 34) return t < 3 || c != other;
		return 1'b0;
	endfunction : refd
	// behavioural command model; several terminals of one code combine
	function automatic ddif_pkg::ddif_cmd_s exp_cmd(int cd[5], logic [4:0] lv, bit cl, bit dt,
		bit dv);
		ddif_pkg::ddif_cmd_s e;
		bit h[64];
		bit l[64];
		e = '0;
		for (int i = 0; i < 5; i++) begin
			if (lv[i]) h[cd[i]] = 1'b1;
			else l[cd[i]] = 1'b1;
		end
		e.coast = l[2] | l[3];
		e.quick_stop = l[4];
		e.dc_brake = l[5] & dt & dv;
		e.ramp_stop = l[6] | l[26];
		e.run = !(e.coast | e.quick_stop | e.dc_brake | e.ramp_stop)
			& (h[7] | (h[10] & !cl) | h[11] | h[12] | h[27] | h[33]);
		e.reverse = (h[9] | h[10]) & !cl;
		e.dir_lock_cw = h[11];
		e.dir_lock_ccw = h[12];
		e.inch = h[13] & !(e.coast | e.quick_stop | e.dc_brake);
		e.ramp2 = h[21];
		e.preset_sel = {h[23], h[22]};
		e.preset_on = h[24];
		e.setup_sel = {h[32], h[31]};
		e.slow_down = h[20];
		e.catch_up = h[19] & !h[20];
		e.freeze_ref = h[14];
		e.freeze_out = h[15];
		e.precise_stop = l[26];
		return e;
	endfunction : exp_cmd
	task automatic edge_case(int c, bit tr, bit lv0, bit glitch, int exp);
		@(posedge core_clk);
		func_sel <= 30'(c);
		trip <= tr;
		bounce <= 1'b0;
		want <= {4'h0, lv0};
		repeat (14) @(posedge core_clk);
		pulses = 0;
		want <= {4'h0, !lv0};
		if (glitch) begin
			repeat (2) @(posedge core_clk);
			want <= {4'h0, lv0};
		end
		repeat (16) @(posedge core_clk);
		chk(pulses, exp);
	endtask : edge_case
	////////////////////////////////////////////////////////////////////////////
	initial begin
		int cd[5];
		int c;
		void'($urandom(32'haf1749b4));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk(func_eff, ddif_pkg::SEL_RESET);
		chk(cmd, 0);
		chk(refused, 5'h00);
		$display("test reset done");
		// every code on every terminal, the other terminals unused
		for (int t = 0; t < 5; t++) begin
			for (c = 0; c < 41; c++) begin
				@(posedge core_clk);
				func_sel <= 30'(c) << (6 * t);
				repeat (2) @(posedge core_clk);
				#1;
				chk(refused[t], refd(t, c, 1'b0, 0));
				chk(func_eff[6*t+:6], refd(t, c, 1'b0, 0) ? 0 : c);
			end
		end
		// encoder pairs and the pulse-output interlock
		for (c = 28; c < 37; c++) begin
			if (c == 30) continue;
			@(posedge core_clk);
			pulse_mode <= 1'b1;
			func_sel <= {6'(c), 6'(c), 18'h0};
			repeat (2) @(posedge core_clk);
			#1;
			chk(refused[4:3], {refd(4, c, 1'b1, c), refd(3, c, 1'b1, c)});
		end
		pulse_mode <= 1'b0;
		$display("test function select done");
		edge_case(1, 1'b0, 1'b0, 1'b0, 1);
		edge_case(1, 1'b0, 1'b1, 1'b0, 0);
		edge_case(1, 1'b1, 1'b0, 1'b0, 0);
		edge_case(1, 1'b0, 1'b0, 1'b1, 0);
		edge_case(3, 1'b0, 1'b1, 1'b0, 1);
		edge_case(3, 1'b0, 1'b0, 1'b0, 0);
		trip <= 1'b0;
		$display("test alarm clear done");
		// mid-run reset with a reset-function pin held high: no clear after release
		@(posedge core_clk);
		func_sel <= 30'(1);
		want <= 5'h01;
		repeat (14) @(posedge core_clk);
		rst <= 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		pulses = 0;
		chk(cmd, 0);
		chk(func_eff, ddif_pkg::SEL_RESET);
		repeat (16) @(posedge core_clk);
		#1;
		chk(pulses, 0);
		chk(func_eff, 30'(1));
		$display("test mid-run reset done");
		for (int n = 0; n < 150; n++) begin
			for (int i = 0; i < 5; i++) begin
				// precise stop codes exist only on the first two terminals
				cd[i] = (i < 2 && $urandom_range(3) == 0) ? 26 + $urandom_range(1)
					: ok_codes[$urandom_range(26)];
			end
			// no other start source beside reverse-and-start
			for (int i = 0; i < 5; i++) begin
				if (10 inside {cd} && cd[i] inside {7, 8, 11, 12, 27, 33}) cd[i] = 0;
			end
			@(posedge core_clk);
			func_sel <= {6'(cd[4]), 6'(cd[3]), 6'(cd[2]), 6'(cd[1]), 6'(cd[0])};
			want <= 5'($urandom);
			bounce <= 1'($urandom);
			closed_loop <= 1'($urandom);
			dct <= 1'($urandom);
			dcv <= 1'($urandom);
			repeat (18) @(posedge core_clk);
			#1;
			chk(func_eff, {6'(cd[4]), 6'(cd[3]), 6'(cd[2]), 6'(cd[1]), 6'(cd[0])});
			chk(cmd, exp_cmd(cd, want, closed_loop, dct, dcv));
		end
		$display("test terminal commands done");
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		give_verdict();
	end
endmodule : test_ddif_top
`default_nettype wire
